// ---- inc/eeprom_ctrl_pkg.sv ----
// constants, offsets and types shared by the nonvolatile access block
package eeprom_ctrl_pkg;
  // ==================================================
  // bus geometry
  localparam int ADDR_W = 12;
  // ==================================================
  // register byte addresses on the wishbone port
  localparam logic [11:0] PTR_LO_OFS = 12'h180;
  localparam logic [11:0] PTR_HI_OFS = 12'h184;
  localparam logic [11:0] VAL_LO_OFS = 12'h188;
  localparam logic [11:0] CTRL_OFS = 12'h18C;
  localparam logic [11:0] VAL_HI_OFS = 12'h190;
  localparam logic [11:0] UNLOCK_OFS = 12'h194;
  localparam logic [11:0] STAT_OFS = 12'h198;
  // ==================================================
  // access control field positions
  localparam int SPACE_BIT = 7;
  localparam int ERASE_BIT = 4;
  localparam int ABORT_BIT = 3;
  localparam int PERMIT_BIT = 2;
  localparam int GO_BIT = 1;
  localparam int FETCH_BIT = 0;
  // status field position (cycle done flag)
  localparam int DONE_BIT = 0;
  // ==================================================
  // reset values and keys
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  // erase works on 32-word rows, so five low address bits drop out
  localparam int ROW_BITS = 5;
  // ==================================================
  // flash side widths and default write timer count
  localparam int FLASH_AW = 13;
  localparam int FLASH_DW = 14;
  localparam int WRITE_CYCLES_DEF = 1000;
  // ==================================================
  // unlock sequencer states
  typedef enum {UNLK_IDLE, UNLK_GOT1, UNLK_ARMED} unlock_state_type;
endpackage

// ---- inc/nv_array_if.sv ----
// carrier between the access controller and the data memory array
`timescale 1ns/10ps
interface nv_array_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic re; // read strobe, data lands one cycle later
  logic we; // write strobe
  logic [AW-1:0] addr; // byte location
  logic [DW-1:0] wdata; // byte to store
  logic [DW-1:0] rdata; // registered read byte
  modport ctrl (output re, output we, output addr, output wdata, input rdata);
  modport array (input re, input we, input addr, input wdata, output rdata);
endinterface

// ---- rtl/nv_data_array.sv ----
// byte-wide data memory array with registered read port
`timescale 1ns/10ps
module nv_data_array #(
  parameter int DEPTH = 256,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // array port
  nv_array_if.array port
);
  // ==================================================
  // elaboration check
  if (DEPTH < 2 || DW < 1)
  begin : g_chk
    $error("nv_data_array: unsupported geometry");
  end
  logic [DW-1:0] mem [DEPTH]; // storage, no reset like a real array
  logic [DW-1:0] rdata_r; // read register
  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (port.we)
    begin
      mem[port.addr] <= port.wdata;
    end
  end
  // read register, holds until the next read strobe
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rdata_r <= '0;
    end
    else if (port.re)
    begin
      rdata_r <= mem[port.addr];
    end
  end
  assign port.rdata = rdata_r;
endmodule // nv_data_array

// ---- rtl/nv_access_ctrl.sv ----
// nonvolatile memory access controller with wishbone register port
`timescale 1ns/10ps
module nv_access_ctrl
  import eeprom_ctrl_pkg::*;
#(
  parameter int WRITE_CYCLES = eeprom_ctrl_pkg::WRITE_CYCLES_DEF,
  parameter int DATA_DEPTH = 256
) (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [eeprom_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // warm reset sources
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  // program flash port
  output logic [eeprom_ctrl_pkg::FLASH_AW-1:0] flash_addr_o,
  output logic [eeprom_ctrl_pkg::FLASH_DW-1:0] flash_wdata_o,
  output logic flash_rd_o,
  output logic flash_commit_o,
  output logic flash_erase_o,
  input wire logic [eeprom_ctrl_pkg::FLASH_DW-1:0] flash_rdata_i
);
  import eeprom_ctrl_pkg::*;
  // ==================================================
  // elaboration checks
  if (WRITE_CYCLES < 8 || WRITE_CYCLES > 4096 || DATA_DEPTH < 2 || DATA_DEPTH > 256)
  begin : g_chk
    $error("nv_access_ctrl: unsupported parameter value");
  end
  localparam int DAW = $clog2(DATA_DEPTH); // data array address width
  localparam int CW = $clog2(WRITE_CYCLES + 1); // timer width
  localparam logic [CW-1:0] CNT_LAST = CW'(WRITE_CYCLES - 1);
  // ==================================================
  // state declarations
  nv_array_if #(.AW(DAW), .DW(8)) arr (); // data array carrier
  logic ack_r; // bus answer
  logic [31:0] dat_r; // registered read data
  logic [7:0] rd_mux; // read data before the register
  logic space_r; // space_select
  logic erase_r; // row_erase_select
  logic abort_r; // cycle_abort_flag
  logic permit_r; // cycle_permit
  logic go_r; // program_cycle_go
  logic fetch_r; // fetch_go
  logic done_r; // cycle_done_flag
  logic [7:0] ptr_lo_r; // location_pointer_low
  logic [4:0] ptr_hi_r; // location_pointer_high
  logic [7:0] val_lo_r; // value_low_reg
  logic [5:0] val_hi_r; // value_high_reg
  logic [CW-1:0] cnt_r; // write timer
  unlock_state_type unlk_r; // unlock sequencer
  // ==================================================
  // bus decode
  logic req; // live request
  logic wr_en; // write takes effect this edge
  logic wr_ctrl, wr_stat, wr_unlk; // per-register write strobes
  logic warm_rst; // external or watchdog reset
  logic start; // write cycle begins
  logic write_end; // write cycle finishes
  logic fetch_start; // read begins
  assign req = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master sees ack high
  assign wr_en = req & ack_r & wb_we_i & wb_sel_i[0];
  assign wr_ctrl = wr_en && (wb_adr_i == CTRL_OFS);
  assign wr_stat = wr_en && (wb_adr_i == STAT_OFS);
  assign wr_unlk = wr_en && (wb_adr_i == UNLOCK_OFS);
  assign warm_rst = ~external_reset_pin_n | watchdog_reset;
  // go only rises with permit held and the unlock keys seen
  assign start = wr_ctrl && wb_dat_i[GO_BIT] && permit_r && !go_r
    && (unlk_r == UNLK_ARMED) && !warm_rst;
  assign write_end = go_r && (cnt_r == CNT_LAST) && !warm_rst;
  // a zero written to fetch_go does nothing
  assign fetch_start = wr_ctrl && wb_dat_i[FETCH_BIT] && !fetch_r && !warm_rst;
  // ==================================================
  // wishbone answer: one wait state, ack drops the cycle after
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= req & ~ack_r;
    end
  end
  // read mux; unmapped and unlock port answer zero
  always_comb
  begin
    case (wb_adr_i)
      PTR_LO_OFS: rd_mux = ptr_lo_r;
      PTR_HI_OFS: rd_mux = {3'b000, ptr_hi_r};
      VAL_LO_OFS: rd_mux = val_lo_r;
      VAL_HI_OFS: rd_mux = {2'b00, val_hi_r};
      CTRL_OFS: rd_mux = {space_r, 2'b00, erase_r, abort_r, permit_r, go_r, fetch_r};
      STAT_OFS: rd_mux = {7'b000_0000, done_r};
      default: rd_mux = BYTE_RST;
    endcase
  end
  // read data captured as ack rises, stable while ack is high
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      dat_r <= '0;
    end
    else if (req && !ack_r)
    begin
      dat_r <= {24'h00_0000, rd_mux};
    end
  end
  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  // ==================================================
  // plain control bits; warm reset returns them to data space
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      space_r <= 1'b0;
      erase_r <= 1'b0;
      permit_r <= 1'b0;
    end
    else if (warm_rst)
    begin
      space_r <= 1'b0;
      erase_r <= 1'b0;
      permit_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      space_r <= wb_dat_i[SPACE_BIT];
      erase_r <= wb_dat_i[ERASE_BIT];
      permit_r <= wb_dat_i[PERMIT_BIT]; // clearing later leaves a running write alone
    end
  end
  // write cycle and its timer; software cannot clear go
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      go_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (warm_rst)
    begin
      go_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (start)
    begin
      go_r <= 1'b1;
      cnt_r <= '0;
    end
    else if (write_end)
    begin
      go_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (go_r)
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  // abort flag: set by a cut write, cleared on clean completion
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      abort_r <= 1'b0;
    end
    else if (warm_rst && go_r)
    begin
      abort_r <= 1'b1;
    end
    else if (write_end)
    begin
      abort_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      abort_r <= wb_dat_i[ABORT_BIT];
    end
  end
  // fetch_go lives exactly one cycle, the data lands as it drops
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      fetch_r <= 1'b0;
    end
    else
    begin
      fetch_r <= fetch_start;
    end
  end
  // done flag: set wins over a write-one-to-clear in the same edge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      done_r <= 1'b0;
    end
    else if (write_end)
    begin
      done_r <= 1'b1;
    end
    else if (wr_stat && wb_dat_i[DONE_BIT])
    begin
      done_r <= 1'b0;
    end
  end
  // unlock sequencer: any stray write breaks the key sequence
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      unlk_r <= UNLK_IDLE;
    end
    else if (warm_rst)
    begin
      unlk_r <= UNLK_IDLE;
    end
    else if (wr_en)
    begin
      case (unlk_r)
        UNLK_IDLE, UNLK_ARMED, UNLK_GOT1:
        begin
          if (wr_unlk && wb_dat_i[7:0] == UNLOCK_KEY1)
          begin
            unlk_r <= UNLK_GOT1;
          end
          else if (wr_unlk && unlk_r == UNLK_GOT1 && wb_dat_i[7:0] == UNLOCK_KEY2)
          begin
            unlk_r <= UNLK_ARMED;
          end
          else
          begin
            unlk_r <= UNLK_IDLE;
          end
        end
        default: unlk_r <= UNLK_IDLE;
      endcase
    end
  end
  // pointers; address and data survive a warm reset for a retry
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ptr_lo_r <= BYTE_RST;
      ptr_hi_r <= '0;
    end
    else if (wr_en && wb_adr_i == PTR_LO_OFS)
    begin
      ptr_lo_r <= wb_dat_i[7:0];
    end
    else if (wr_en && wb_adr_i == PTR_HI_OFS)
    begin
      ptr_hi_r <= wb_dat_i[4:0];
    end
  end
  // value registers: replaced only by a landing read or a bus write
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      val_lo_r <= BYTE_RST;
      val_hi_r <= '0;
    end
    else if (fetch_r && !space_r)
    begin
      val_lo_r <= arr.rdata;
    end
    else if (fetch_r)
    begin
      val_lo_r <= flash_rdata_i[7:0];
      val_hi_r <= flash_rdata_i[13:8];
    end
    else if (wr_en && wb_adr_i == VAL_LO_OFS)
    begin
      val_lo_r <= wb_dat_i[7:0];
    end
    else if (wr_en && wb_adr_i == VAL_HI_OFS)
    begin
      val_hi_r <= wb_dat_i[5:0];
    end
  end
  // ==================================================
  // array strobes; read target from the space bit of the fetch write, write target from space_r
  assign arr.re = fetch_start && !wb_dat_i[SPACE_BIT];
  assign arr.we = write_end && !space_r;
  // pointer high bits fall outside the byte-wide data array
  assign arr.addr = ptr_lo_r[DAW-1:0];
  assign arr.wdata = val_lo_r;
  assign flash_rd_o = fetch_start && wb_dat_i[SPACE_BIT];
  assign flash_commit_o = write_end && space_r;
  assign flash_erase_o = erase_r;
  // a row erase ignores the word bits inside the 32-word row
  assign flash_addr_o = erase_r ? {ptr_hi_r, ptr_lo_r[7:ROW_BITS], 5'b0_0000}
    : {ptr_hi_r, ptr_lo_r};
  assign flash_wdata_o = {val_hi_r, val_lo_r};
  nv_data_array #(.DEPTH(DATA_DEPTH), .DW(8)) u_array (
    .clk_sys(clk_sys),
    .reset(reset),
    .port(arr.array)
  );
  // ==================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence fetch_data_s;
    fetch_start && !wb_dat_i[SPACE_BIT];
  endsequence
  sequence fetch_land_s;
    ##1 fetch_r ##1 (!fetch_r && val_lo_r == arr.rdata);
  endsequence
  permit_gate_a: assert property ($rose(go_r) |-> $past(permit_r))
    else $error("write started without permit");
  key_gate_a: assert property ($rose(go_r) |-> $past(unlk_r == UNLK_ARMED))
    else $error("write started without unlock keys");
  go_hold_a: assert property (go_r && !warm_rst && cnt_r != CNT_LAST |=> go_r)
    else $error("write cycle dropped early");
  done_set_a: assert property (write_end |=> done_r && !go_r && !abort_r)
    else $error("write end did not update flags");
  abort_set_a: assert property (warm_rst && go_r |=> abort_r && !go_r)
    else $error("cut write not flagged");
  fetch_land_a: assert property (fetch_data_s |-> fetch_land_s)
    else $error("read byte late or wrong");
  fetch_clear_a: assert property (fetch_r |=> !fetch_r)
    else $error("fetch_go not cleared");
  value_hold_a: assert property (!fetch_r && !(wr_en && wb_adr_i == VAL_LO_OFS)
    |=> $stable(val_lo_r))
    else $error("value_low changed without cause");
  unlock_zero_a: assert property (req && !ack_r && wb_adr_i == UNLOCK_OFS
    |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("unlock port read not zero");
  ctrl_gap_a: assert property (req && !ack_r && wb_adr_i == CTRL_OFS
    |=> wb_dat_o[6:5] == 2'b00)
    else $error("unimplemented control bits not zero");
  // a flash fetch must land the flash word, not the data array byte
  space_target_a: assert property (fetch_r && space_r
    |=> {val_hi_r, val_lo_r} == $past(flash_rdata_i))
    else $error("flash read did not land flash word");
  // with permit low and nothing running, no write cycle may begin
  no_write_locked_a: assert property (!go_r && !permit_r |=> !go_r)
    else $error("write started while permit low");
  erase_row_a: assert property (flash_commit_o && erase_r
    |-> flash_erase_o && flash_addr_o[4:0] == 5'b0_0000)
    else $error("row erase address not aligned");
endmodule // nv_access_ctrl

// ---- tb/tb_top.sv ----
// self-checking bench for the nonvolatile access controller
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_top;
  import eeprom_ctrl_pkg::*;
  // ==================================================
  // clock, reset and bus drive
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0; // bus request
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'hF; // all lanes enabled; lane 0 is dropped for one write in the lane test
  logic [31:0] dat = 32'h0000_0000;
  logic ext_reset_n = 1'b1; // warm reset sources
  logic watchdog_reset = 1'b0;
  logic [13:0] flash_rdata = 14'h2ABC; // flash word handed back on a read
  // design outputs
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [12:0] flash_addr_o;
  logic [13:0] flash_wdata_o;
  logic flash_rd_o;
  logic flash_commit_o;
  logic flash_erase_o;
  // bench bookkeeping
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int rd_seen = 0; // flash read strobes seen
  int commits = 0; // flash commit strobes seen
  logic [12:0] rd_addr = 13'h0000;
  logic [31:0] rd; // data of the last bus cycle
  // ==================================================
  // clock and design under test
  always #2.5 clk_sys = ~clk_sys;
  // short write timer keeps the run brief
  nv_access_ctrl #(.WRITE_CYCLES(16), .DATA_DEPTH(256)) nv_access_ctrl_i (
    .clk_sys(clk_sys), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_reset_pin_n(ext_reset_n), .watchdog_reset(watchdog_reset),
    .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
    .flash_rd_o(flash_rd_o), .flash_commit_o(flash_commit_o),
    .flash_erase_o(flash_erase_o), .flash_rdata_i(flash_rdata)
  );
  // ==================================================
  // closing report
  task automatic end_of_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // strobe monitor and hang guard; run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (flash_rd_o === 1'b1)
    begin
      rd_seen <= rd_seen + 1;
      rd_addr <= flash_addr_o;
    end
    if (flash_commit_o === 1'b1)
      commits <= commits + 1;
    if (cycles == 5000)
    begin
      err_total++;
      end_of_test();
    end
  end
  // ==================================================
  // bus tasks: hold request until ack is sampled, then idle one cycle
  task automatic wb_cycle(input logic w, input logic [11:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_sys);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    wb_cycle(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    wb_cycle(1'b0, a, 8'h00);
    `CHK(rd, {24'h00_0000, e})
  endtask
  // unlock keys then the control byte carrying go
  task automatic start_write(input logic [7:0] c);
    wr(UNLOCK_OFS, UNLOCK_KEY1);
    wr(UNLOCK_OFS, UNLOCK_KEY2);
    wr(CTRL_OFS, c);
  endtask
  // poll go with a bounded count; a stuck timer shows as a mismatch
  task automatic wait_idle;
    int n;
    n = 0;
    wb_cycle(1'b0, CTRL_OFS, 8'h00);
    while (rd[GO_BIT] !== 1'b0 && n < 40)
    begin
      n++;
      wb_cycle(1'b0, CTRL_OFS, 8'h00);
    end
    `CHK(rd[GO_BIT], 1'b0)
  endtask
  // ==================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // power-on values, read-as-zero places
    chk_rd(CTRL_OFS, 8'h00);
    chk_rd(STAT_OFS, 8'h00);
    chk_rd(UNLOCK_OFS, 8'h00);
    chk_rd(12'h1FC, 8'h00);
    wr(CTRL_OFS, 8'h60);
    chk_rd(CTRL_OFS, 8'h00);
    // warm reset in mid-write, from each source
    for (int i = 0; i < 2; i++)
    begin
      wr(PTR_LO_OFS, 8'h3C);
      wr(CTRL_OFS, 8'h04);
      start_write(8'h06);
      if (i == 0)
        watchdog_reset <= 1'b1;
      else
        ext_reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      watchdog_reset <= 1'b0;
      ext_reset_n <= 1'b1;
      @(posedge clk_sys);
      chk_rd(CTRL_OFS, 8'h08);
      chk_rd(STAT_OFS, 8'h00);
    end
    // full data write; clearing permit and go mid-run must not stop it
    wr(VAL_LO_OFS, 8'hA5);
    wr(CTRL_OFS, 8'h0C);
    start_write(8'h0E);
    chk_rd(CTRL_OFS, 8'h0E);
    wr(CTRL_OFS, 8'h08);
    chk_rd(CTRL_OFS, 8'h0A);
    wait_idle();
    chk_rd(CTRL_OFS, 8'h00);
    chk_rd(STAT_OFS, 8'h01);
    wr(STAT_OFS, 8'h01);
    chk_rd(STAT_OFS, 8'h00);
    // data read back over a scrubbed value register
    wr(VAL_LO_OFS, 8'h00);
    wr(PTR_LO_OFS, 8'h3C);
    wr(CTRL_OFS, 8'h01);
    chk_rd(VAL_LO_OFS, 8'hA5);
    chk_rd(CTRL_OFS, 8'h00);
    chk_rd(VAL_LO_OFS, 8'hA5);
    wr(VAL_LO_OFS, 8'h5A);
    chk_rd(VAL_LO_OFS, 8'h5A);
    // lane 0 disabled: the write is acked but must not land
    sel <= 4'hE;
    wr(VAL_LO_OFS, 8'h11);
    sel <= 4'hF;
    chk_rd(VAL_LO_OFS, 8'h5A);
    // refused starts: no permit, keys reversed, keys broken by another write
    start_write(8'h02);
    chk_rd(CTRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'h04);
    wr(UNLOCK_OFS, UNLOCK_KEY2);
    wr(UNLOCK_OFS, UNLOCK_KEY1);
    wr(CTRL_OFS, 8'h06);
    chk_rd(CTRL_OFS, 8'h04);
    wr(UNLOCK_OFS, UNLOCK_KEY1);
    wr(PTR_LO_OFS, 8'h3C);
    wr(UNLOCK_OFS, UNLOCK_KEY2);
    wr(CTRL_OFS, 8'h06);
    chk_rd(CTRL_OFS, 8'h04);
    chk_rd(STAT_OFS, 8'h00);
    // flash read picks the other space
    wr(PTR_HI_OFS, 8'h12);
    wr(PTR_LO_OFS, 8'h34);
    wr(CTRL_OFS, 8'h81);
    `CHK(rd_seen, 1)
    `CHK(rd_addr, 13'h1234)
    chk_rd(VAL_LO_OFS, 8'hBC);
    chk_rd(VAL_HI_OFS, 8'h2A);
    `CHK(flash_wdata_o, 14'h2ABC)
    chk_rd(CTRL_OFS, 8'h80);
    // row erase: row-aligned address, one commit at the end
    wr(CTRL_OFS, 8'h94);
    `CHK(flash_erase_o, 1'b1)
    `CHK(flash_addr_o, 13'h1220)
    start_write(8'h96);
    wait_idle();
    `CHK(commits, 1)
    chk_rd(STAT_OFS, 8'h01);
    end_of_test();
  end
endmodule // tb_top
